// [sim/serial_block_tb.sv]
// self-checking bench for the serial block data path
`timescale 1ns/1ns
module serial_block_tb
  import serial_pkg::*;
;
  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              sclk_m;
  logic              sdo;
  logic              sdi;
  logic              sclk_s;
  logic              ss_n;
  logic [DATA_W-1:0] rv;
  int                num_errors;
  int                checks_done;

  initial clk = 1'b0;
  always #50 clk = ~clk;

  serial_block uut (
    .CLOCK_I (clk),
    .RESETN_I(rst_n),
    .ADDR_I  (addr),
    .WDATA_I (wdata),
    .WR_I    (wr),
    .RD_I    (rd),
    .RDATA_O (rdata),
    .SCLK_O  (sclk_m),
    .SDO_O   (sdo),
    .SDI_I   (sdi),
    .SCLK_I  (sclk_s),
    .SS_N_I  (ss_n)
  );

  spi_partner link (
    .sclk_i(sclk_m),
    .dout_i(sdo),
    .sdi_o (sdi),
    .sclk_o(sclk_s),
    .ss_n_o(ss_n)
  );

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd_reg

  task automatic wait_done();
    int n;
    n = 0;
    rd_reg(REG_CTRL, rv);
    while (rv[STAT_DONE] !== 1'b1) begin
      n++;
      if (n > 100) begin
        num_errors++;
        $display("ERROR %0t: transfer never completed", $time);
        wrap_up();
      end
      rd_reg(REG_CTRL, rv);
    end
  endtask : wait_done

  task automatic t_reset();
    rd_reg(REG_CTRL, rv);
    chk(rv, 8'h10);
    rd_reg(REG_FUNC, rv);
    chk(rv, 8'h00);
    rd_reg(REG_SHIFTER, rv);
    chk(rv, 8'h00);
    wr_reg(REG_RX_HOLD, 8'h5a);
    rd_reg(REG_RX_HOLD, rv);
    chk(rv, 8'h00);
    rd_reg(3'h5, rv);
    chk(rv, 8'h00);
  endtask : t_reset

  task automatic t_master();
    link.frame(8'hc3, 8'h3c);
    wr_reg(REG_CTRL, 8'h01);
    wr_reg(REG_TX_HOLD, 8'ha5);
    wr_reg(REG_TX_HOLD, 8'h5a);
    rd_reg(REG_CTRL, rv);
    chk(rv, 8'h01);
    wait_done();
    rd_reg(REG_RX_HOLD, rv);
    chk(rv, 8'hc3);
    wait_done();
    rd_reg(REG_RX_HOLD, rv);
    chk(rv, 8'h3c);
    rd_reg(REG_CTRL, rv);
    chk(rv, 8'h11);
    repeat (20) @(posedge clk);
    chk(8'(link.frames_q), 8'h02);
    chk(link.got_q[0], 8'ha5);
    chk(link.got_q[1], 8'h5a);
  endtask : t_master

  task automatic t_overrun();
    link.frame(8'h11, 8'h22);
    wr_reg(REG_TX_HOLD, 8'h81);
    wr_reg(REG_TX_HOLD, 8'h18);
    repeat (160) @(posedge clk);
    rd_reg(REG_CTRL, rv);
    chk(rv, 8'hf1);
    rd_reg(REG_RX_HOLD, rv);
    chk(rv, 8'h22);
    rd_reg(REG_CTRL, rv);
    chk(rv, 8'h11);
    chk(link.got_q[1], 8'h18);
  endtask : t_overrun

  task automatic t_lsb_off();
    link.frame(8'h01, 8'hff);
    wr_reg(REG_CTRL, 8'h03);
    wr_reg(REG_TX_HOLD, 8'h01);
    wait_done();
    rd_reg(REG_RX_HOLD, rv);
    chk(rv, 8'h80);
    repeat (20) @(posedge clk);
    chk(link.got_q[0], 8'h80);
    wr_reg(REG_CTRL, 8'h00);
    wr_reg(REG_TX_HOLD, 8'h77);
    repeat (100) @(posedge clk);
    chk(8'(link.frames_q), 8'h01);
    rd_reg(REG_CTRL, rv);
    chk(rv, 8'h00);
  endtask : t_lsb_off

  task automatic t_slave();
    wr_reg(REG_FUNC, 8'h01);
    wr_reg(REG_TX_HOLD, 8'h3c);
    wr_reg(REG_CTRL, 8'h01);
    repeat (4) @(posedge clk);
    rd_reg(REG_CTRL, rv);
    chk(rv, 8'h11);
    link.drive(8'h96);
    chk(link.seen_q, 8'h3c);
    repeat (8) @(posedge clk);
    rd_reg(REG_CTRL, rv);
    chk({7'h0, rv[STAT_RXF]}, 8'h01);
    rd_reg(REG_RX_HOLD, rv);
    chk(rv, 8'h96);
  endtask : t_slave

  task automatic t_uart();
    int         i;
    int         n;
    logic [9:0] frm;
    frm = {1'b1, 8'h4d, 1'b0};
    wr_reg(REG_CTRL, 8'h00);
    wr_reg(REG_FUNC, 8'h02);
    wr_reg(REG_CTRL, 8'h01);
    wr_reg(REG_RX_HOLD, 8'hff);
    wr_reg(REG_TX_HOLD, 8'h4d);
    n = 0;
    while (sdo !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk({7'h0, sdo}, 8'h00);
    // sample mid-bit so a one-cycle slip of the bit timer is tolerated
    repeat (8) @(negedge clk);
    for (i = 0; i < 10; i++) begin
      chk({7'h0, sdo}, {7'h0, frm[i]});
      repeat (16) @(negedge clk);
    end
    rd_reg(REG_RX_HOLD, rv);
    chk(rv, 8'h00);
    rd_reg(REG_CTRL, rv);
    chk(rv, 8'h19);
  endtask : t_uart

  initial begin
    rst_n = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    num_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_master();
    t_overrun();
    t_lsb_off();
    t_slave();
    t_uart();
    wrap_up();
  end
endmodule : serial_block_tb

// [sim/spi_partner.sv]
// link partner: slave for the master function, master for the slave one
`timescale 1ns/1ns
module spi_partner (
  // block side of the link
  input  wire logic sclk_i,
  input  wire logic dout_i,
  // partner drives
  output logic      sdi_o,
  output logic      sclk_o,
  output logic      ss_n_o
);
  logic [7:0] reply_q;
  logic [7:0] next_q;
  logic [7:0] seen_q;
  logic [7:0] got_q [4];
  int         bits_q;
  int         frames_q;

  assign sdi_o = reply_q[7];

  initial begin
    sclk_o = 1'b0;
    ss_n_o = 1'b1;
    reply_q = 8'h00;
    frames_q = 0;
    bits_q = 0;
  end

  task automatic frame(input logic [7:0] a, input logic [7:0] b);
    reply_q = a;
    next_q = b;
    bits_q = 0;
    frames_q = 0;
  endtask : frame

  // mode 0 slave: sample on rise, next bit on fall
  always @(posedge sclk_i) begin
    seen_q = {seen_q[6:0], dout_i};
    bits_q++;
  end

  // after the byte the line shows the first bit of the next reply (next_q), not a hold
  always @(negedge sclk_i) begin
    if (bits_q == 8) begin
      if (frames_q < 4) got_q[frames_q] = seen_q;
      frames_q++;
      bits_q = 0;
      reply_q = next_q;
    end else begin
      reply_q = {reply_q[6:0], ~reply_q[0]};
    end
  end

  // mode 0 master, 800 ns clock that stands still outside the frame
  task automatic drive(input logic [7:0] b);
    reply_q = b;
    ss_n_o = 1'b0;
    #800;
    repeat (8) begin
      sclk_o = 1'b1;
      seen_q = {seen_q[6:0], dout_i};
      #400;
      sclk_o = 1'b0;
      reply_q = {reply_q[6:0], ~reply_q[0]};
      #400;
    end
    ss_n_o = 1'b1;
  endtask : drive
endmodule : spi_partner

// [verilog/serial_block.sv]
// serial block data path: SPI master, SPI slave and async transmitter
//
// Function
// - SPI modes: three data, 8-bit control/status
// - transmitter: three data, 5-bit control/status
// - shift register hidden from software
// - transmitter shifter only shifts out
// - idle write loads shifter next edge, starts
// - write while busy waits as next byte
// - holding write clears vacant flag
// - holding-to-shifter move sets vacant flag
// - byte done copies shifter, sets occupied flag
// - receive buffer read-only, read clears occupied
// - slave holding handshake same as master
// - slave byte goes to receive buffer, flagged
// - transmitter idle write starts after setup edge
// - transmitter ignores third data register
// - enable bit starts, stops function synchronously
// - SPI phase, polarity, lsb-first read/write bits
// - SPI overrun and complete read-only status
// - transmitter enable, parity bits, status bits
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
module serial_block
  import serial_pkg::*;
(
  // clock and reset
  input  wire logic              CLOCK_I,
  input  wire logic              RESETN_I,
  // register port
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic [DATA_W-1:0] WDATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output logic      [DATA_W-1:0] RDATA_O,
  // serial link
  output logic                   SCLK_O,
  output logic                   SDO_O,
  input  wire logic              SDI_I,
  input  wire logic              SCLK_I,
  input  wire logic              SS_N_I
);

  localparam int BYTE_CYC = 16 * int'(SPI_HALF_CYC);
  localparam int BYTE_LO  = BYTE_CYC - 2;
  localparam int BYTE_HI  = BYTE_CYC + 2;

  func_t             func_q;
  state_t            state_q;
  logic [3:0]        ctrl_q;
  logic [DATA_W-1:0] hold_q;
  logic [DATA_W-1:0] shift_q;
  logic [DATA_W-1:0] rx_q;
  logic              vacant_q;
  logic              rx_full_q;
  logic              overrun_q;
  logic              done_q;
  logic              parity_q;
  logic [2:0]        bit_q;
  logic [3:0]        edge_q;
  logic              sclk_last_q;
  logic [2:0]        pins_s;
  logic              tick;

  logic en;
  logic is_uart;
  logic is_master;
  logic is_slave;
  logic sdi_s;
  logic sclk_s;
  logic ss_n_s;
  logic wr_tx;
  logic rd_rx;
  logic rd_ctrl;
  logic load;
  logic slave_act;
  logic edge_ev;
  logic lead;
  logic samp;
  logic spi_done;
  logic uart_done;
  logic master_end;

  // pins from outside the clock domain
  serial_sync #(.W(3)) u_sync (
    .clk_i   (CLOCK_I),
    .rst_n_i (RESETN_I),
    .async_i ({SDI_I, SCLK_I, !SS_N_I}),
    .sync_o  (pins_s)
  );

  assign sdi_s  = pins_s[2];
  assign sclk_s = pins_s[1];
  // select rides the chain inverted so a reset chain reads deselected
  assign ss_n_s = !pins_s[0];

  tick_divider u_div (
    .clk_i    (CLOCK_I),
    .rst_n_i  (RESETN_I),
    .run_i    (state_q != ST_IDLE && !is_slave),
    .period_i (is_uart ? UART_BIT_CYC : SPI_HALF_CYC),
    .tick_o   (tick)
  );

  function automatic logic [DATA_W-1:0] shift_in(
    input logic [DATA_W-1:0] s,
    input logic              b,
    input logic              lsb
  );
    shift_in = lsb ? {b, s[DATA_W-1:1]} : {s[DATA_W-2:0], b};
  endfunction : shift_in

  function automatic logic top_bit(
    input logic [DATA_W-1:0] s,
    input logic              lsb
  );
    top_bit = lsb ? s[0] : s[DATA_W-1];
  endfunction : top_bit

  assign en        = ctrl_q[CTL_EN];
  assign is_uart   = (func_q == FN_UART);
  assign is_master = (func_q == FN_MASTER);
  assign is_slave  = (func_q == FN_SLAVE);
  assign wr_tx     = WR_I && (ADDR_I == REG_TX_HOLD);
  // receive buffer has no role for the transmitter
  assign rd_rx     = RD_I && (ADDR_I == REG_RX_HOLD) && !is_uart;
  assign rd_ctrl   = RD_I && (ADDR_I == REG_CTRL);

  // slave takes a new byte only while deselected or at byte end
  assign load = en && !vacant_q && state_q == ST_IDLE
              && (!is_slave || ss_n_s || spi_done);

  // bit events: divider ticks for master, master's clock for slave
  assign slave_act = en && is_slave && !ss_n_s;
  assign edge_ev   = is_master ? (state_q == ST_SPI && tick)
                   : (slave_act && sclk_s != sclk_last_q);
  assign lead      = is_master ? !edge_q[0] : (sclk_s != ctrl_q[CTL_CPOL]);
  assign samp      = lead ^ ctrl_q[CTL_CPHA];
  assign spi_done  = !is_uart && edge_ev && samp && bit_q == BIT_LAST;
  assign master_end = is_master && state_q == ST_SPI && tick
                    && edge_q == EDGE_LAST;
  assign uart_done  = is_uart && state_q == ST_STOP && tick;

  // configuration registers
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      ctrl_q <= CTRL_RESET;
      func_q <= FN_MASTER;
    end else if (WR_I && ADDR_I == REG_CTRL) begin
      ctrl_q <= WDATA_I[3:0];
    end else if (WR_I && ADDR_I == REG_FUNC) begin
      func_q <= func_t'(WDATA_I[1:0]);
    end
  end

  // transmit holding buffer and its vacant flag
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      hold_q   <= DATA_RESET;
      vacant_q <= 1'b1;
    end else if (wr_tx) begin
      // a write always wins; software must wait for vacant
      hold_q   <= WDATA_I;
      vacant_q <= 1'b0;
    end else if (load) begin
      vacant_q <= 1'b1;
    end
  end

  // sequencer
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I || !en) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (load && is_uart) begin
            state_q <= ST_START;
          end else if (load && is_master) begin
            state_q <= ST_SPI;
          end
        end
        ST_SPI: begin
          if (master_end || !is_master) begin
            state_q <= ST_IDLE;
          end
        end
        ST_START: begin
          if (tick) begin
            state_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tick && bit_q == BIT_LAST) begin
            state_q <= ctrl_q[CTL_PEN] ? ST_PARITY : ST_STOP;
          end
        end
        ST_PARITY: begin
          if (tick) begin
            state_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (tick) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // hidden shifter, bit counter and serial output
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I || !en) begin
      shift_q  <= DATA_RESET;
      bit_q    <= BIT_ZERO;
      edge_q   <= EDGE_ZERO;
      SDO_O    <= 1'b1;
      parity_q <= 1'b0;
    end else if (load) begin
      shift_q  <= hold_q;
      bit_q    <= BIT_ZERO;
      edge_q   <= EDGE_ZERO;
      parity_q <= (^hold_q) ^ ctrl_q[CTL_PODD];
      SDO_O    <= is_uart ? 1'b0 : top_bit(hold_q, ctrl_q[CTL_LSB]);
    end else if (is_uart) begin
      if (tick && (state_q == ST_START || state_q == ST_DATA)) begin
        if (state_q == ST_DATA && bit_q == BIT_LAST) begin
          SDO_O <= ctrl_q[CTL_PEN] ? parity_q : 1'b1;
        end else begin
          SDO_O   <= shift_q[0];
          shift_q <= {1'b0, shift_q[DATA_W-1:1]};
          bit_q   <= (state_q == ST_START) ? BIT_ZERO : bit_q + 3'h1;
        end
      end else if (tick && state_q == ST_PARITY) begin
        SDO_O <= 1'b1;
      end
    end else begin
      if (is_slave && ss_n_s) begin
        bit_q <= BIT_ZERO;
      end else if (edge_ev && samp) begin
        shift_q <= shift_in(shift_q, sdi_s, ctrl_q[CTL_LSB]);
        bit_q   <= bit_q + 3'h1;
      end else if (edge_ev) begin
        SDO_O <= top_bit(shift_q, ctrl_q[CTL_LSB]);
      end
      if (is_master && state_q == ST_SPI && tick) begin
        edge_q <= edge_q + 4'h1;
      end
    end
  end

  // master serial clock rests at the polarity level between bytes
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      SCLK_O <= 1'b0;
    end else if (!en || state_q != ST_SPI || master_end) begin
      SCLK_O <= ctrl_q[CTL_CPOL];
    end else if (tick) begin
      SCLK_O <= !SCLK_O;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      sclk_last_q <= 1'b0;
    end else begin
      sclk_last_q <= sclk_s;
    end
  end

  // receive buffer; a completed byte beats a clearing read
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      rx_q      <= DATA_RESET;
      rx_full_q <= 1'b0;
      overrun_q <= 1'b0;
    end else if (spi_done) begin
      rx_q      <= shift_in(shift_q, sdi_s, ctrl_q[CTL_LSB]);
      rx_full_q <= 1'b1;
      overrun_q <= overrun_q || (rx_full_q && !rd_rx);
    end else if (rd_rx) begin
      rx_full_q <= 1'b0;
    end else if (rd_ctrl) begin
      overrun_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      done_q <= 1'b0;
    end else if (spi_done || uart_done) begin
      done_q <= 1'b1;
    end else if (rd_ctrl) begin
      done_q <= 1'b0;
    end
  end

  // read data stand in the cycle after the strobe only
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I || !RD_I) begin
      RDATA_O <= DATA_RESET;
    end else if (ADDR_I == REG_RX_HOLD) begin
      RDATA_O <= is_uart ? DATA_RESET : rx_q;
    end else if (ADDR_I == REG_CTRL && is_uart) begin
      RDATA_O <= {3'h0, done_q, vacant_q, ctrl_q[2:0]};
    end else if (ADDR_I == REG_CTRL) begin
      RDATA_O <= {done_q, overrun_q, rx_full_q, vacant_q, ctrl_q};
    end else if (ADDR_I == REG_FUNC) begin
      RDATA_O <= {6'h00, func_q};
    end else begin
      // shifter and holding buffer read as zero
      RDATA_O <= DATA_RESET;
    end
  end

  a_write_vacant: assert property (
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    wr_tx |=> !vacant_q)
    else $error("holding write did not clear vacant flag");

  a_idle_load: assert property (
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    (en && state_q == ST_IDLE && !vacant_q && !is_slave && !wr_tx
     && !(WR_I && ADDR_I != REG_TX_HOLD))
    |=> (state_q != ST_IDLE && vacant_q && shift_q == $past(hold_q)))
    else $error("idle write did not start a transfer");

  a_busy_hold: assert property (
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    (wr_tx && state_q != ST_IDLE && !is_slave)
    |=> (hold_q == $past(WDATA_I) && !vacant_q))
    else $error("busy write lost the next byte");

  a_rx_done: assert property (
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    spi_done |=> (rx_full_q && rx_q == $past(shift_in(shift_q, sdi_s,
                                                    ctrl_q[CTL_LSB]))))
    else $error("completed byte not in receive buffer");

  a_rx_clear: assert property (
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    (rd_rx && !spi_done) |=> !rx_full_q)
    else $error("receive read did not clear occupied flag");

  a_overrun_set: assert property (
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    (spi_done && rx_full_q && !rd_rx) |=> overrun_q)
    else $error("overrun not flagged");

  a_master_len: assert property (
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    $rose(state_q == ST_SPI) |-> ##[BYTE_LO:BYTE_HI] (state_q != ST_SPI))
    else $error("master byte not sixteen half periods");

  a_master_rest: assert property (
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    (state_q == ST_IDLE && $past(state_q) == ST_IDLE && is_master && en)
    |-> SCLK_O == $past(ctrl_q[CTL_CPOL]))
    else $error("master clock moved while idle");

  a_uart_frame: assert property (
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    (state_q == ST_START |-> !SDO_O) and (state_q == ST_STOP |-> SDO_O))
    else $error("start or stop bit level wrong");

  a_disable_idle: assert property (
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    !en |=> state_q == ST_IDLE)
    else $error("disabled block left idle");

endmodule : serial_block

// [verilog/serial_pkg.sv]
// constants, register map and types of the serial block data path
package serial_pkg;

  // register port widths
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] REG_SHIFTER = 3'h0;
  localparam logic [ADDR_W-1:0] REG_TX_HOLD = 3'h1;
  localparam logic [ADDR_W-1:0] REG_RX_HOLD = 3'h2;
  localparam logic [ADDR_W-1:0] REG_CTRL    = 3'h3;
  localparam logic [ADDR_W-1:0] REG_FUNC    = 3'h4;

  // control/status bits, both SPI functions
  localparam int CTL_EN    = 0;
  localparam int CTL_LSB   = 1;
  localparam int CTL_CPHA  = 2;
  localparam int CTL_CPOL  = 3;
  localparam int STAT_TXE  = 4;
  localparam int STAT_RXF  = 5;
  localparam int STAT_OVR  = 6;
  localparam int STAT_DONE = 7;

  // control/status bits, transmitter function (5 bits wide)
  localparam int CTL_PEN    = 1;
  localparam int CTL_PODD   = 2;
  localparam int USTAT_TXE  = 3;
  localparam int USTAT_DONE = 4;

  localparam logic [3:0]        CTRL_RESET  = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RESET  = 8'h00;
  localparam logic [2:0]        BIT_LAST    = 3'h7;
  localparam logic [3:0]        EDGE_LAST   = 4'hf;
  localparam logic [2:0]        BIT_ZERO    = 3'h0;
  localparam logic [3:0]        EDGE_ZERO   = 4'h0;

  // timing
  localparam int CLK_NS      = 100;
  localparam int SPI_HALF_NS = 400;
  localparam int UART_BIT_NS = 1600;
  localparam logic [7:0] SPI_HALF_CYC = 8'(SPI_HALF_NS / CLK_NS);
  localparam logic [7:0] UART_BIT_CYC = 8'(UART_BIT_NS / CLK_NS);

  typedef enum logic [1:0] {
    FN_MASTER = 2'b00,
    FN_SLAVE  = 2'b01,
    FN_UART   = 2'b10
  } func_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SPI    = 3'b001,
    ST_START  = 3'b010,
    ST_DATA   = 3'b011,
    ST_PARITY = 3'b100,
    ST_STOP   = 3'b101
  } state_t;

endpackage : serial_pkg

// [verilog/serial_sync.sv]
// two flip-flop synchroniser, one chain per bit
`timescale 1ns/1ns
module serial_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          meta_q[g] <= 1'b0;
          sync_o[g] <= 1'b0;
        end else begin
          meta_q[g] <= async_i[g];
          sync_o[g] <= meta_q[g];
        end
      end
    end
  endgenerate
endmodule : serial_sync

// [verilog/tick_divider.sv]
// period divider: one-cycle tick every period_i cycles while running
`timescale 1ns/1ns
module tick_divider (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       run_i,
  input  wire logic [7:0] period_i,
  output logic            tick_o
);
  logic [7:0] count_q;

  // restarts from zero whenever run drops, so each byte starts clean
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !run_i) begin
      count_q <= 8'h00;
      tick_o  <= 1'b0;
    end else if (count_q == period_i - 8'h01) begin
      count_q <= 8'h00;
      tick_o  <= 1'b1;
    end else begin
      count_q <= count_q + 8'h01;
      tick_o  <= 1'b0;
    end
  end
endmodule : tick_divider
